//--- sal_map.svh
// Register indices, field positions and reset values of the alarm/limit/polarity bank.
// Assumes byte address = 4 * index on the register bus; data in the low byte.
`ifndef SAL_MAP_SVH
`define SAL_MAP_SVH

// Register indices (byte address is four times these)
`define SAL_IDX_MON   6'h17
`define SAL_IDX_V0    6'h19
`define SAL_IDX_V1    6'h1a
`define SAL_IDX_T     6'h1b
`define SAL_IDX_CSI   6'h1c
`define SAL_IDX_SNS   6'h1d
`define SAL_IDX_BC    6'h1e
`define SAL_IDX_RSV   6'h1f
`define SAL_IDX_HS    6'h20
`define SAL_IDX_LP    6'h21
`define SAL_IDX_SSTAT 6'h38
`define SAL_IDX_ESTAT 6'h39

// Limit register fields
`define SAL_HI_MSB 6
`define SAL_HI_LSB 4
`define SAL_LO_MSB 2
`define SAL_LO_LSB 0

// Monitor control fields
`define SAL_EN_MSB   3
`define SAL_EN_LSB   2
`define SAL_VSEL_MSB 1
`define SAL_VSEL_LSB 0
`define SAL_VSEL_G0  0
`define SAL_VSEL_G1  1
`define SAL_MON_ON   2'h3

// Reset values
`define SAL_RST_HI   3'h6
`define SAL_RST_LO   3'h2
`define SAL_RST_EN   2'h3
`define SAL_RST_VSEL 2'h0
`define SAL_RST_CSI  6'h3f
`define SAL_RST_SNS  6'h00
`define SAL_RST_BC   2'h0
`define SAL_RST_LANE 5'h00

`endif

//--- sal_pkg.sv
// Types shared by the alarm/limit/polarity bank.
// Assumes sal_map.svh carries all numeric constants.
`default_nettype none

package sal_pkg;

    // Upper and lower limit codes of one monitor
    typedef struct packed {
        logic [2:0] upper;
        logic [2:0] lower;
    } sal_limits_t;

    // Sensor flags and masks, bit 5 down to bit 0
    typedef struct packed {
        logic t_over;
        logic t_under;
        logic gpio1_high_alarm_on;
        logic gpio1_low_alarm_on;
        logic gpio0_high_alarm_on;
        logic gpio0_low_alarm_on;
    } sal_sense_t;

    // Clock lane at bit 4, data lanes 3..0 below
    typedef struct packed {
        logic       clk;
        logic [3:0] data;
    } sal_lane_t;

    // Link event flags: back channel 7:6, receive errors 5:0
    typedef struct packed {
        logic [1:0] bc;
        logic [5:0] csi;
    } sal_events_t;

endpackage : sal_pkg

`default_nettype wire

//--- sal_limit_cmp.sv
// Window comparator for one monitor: flags codes above the upper or below the lower limit.
// Assumes measure and valid come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module sal_limit_cmp #(
    parameter int W = 3
) (
    input  wire logic [W-1:0] measure,
    input  wire logic         valid,
    input  wire logic         active,
    input  wire logic [W-1:0] upper,
    input  wire logic [W-1:0] lower,
    output logic              over_hit,
    output logic              under_hit
);

    // Strict compares: a code equal to a limit raises nothing
    assign over_hit  = valid & active & (measure > upper);
    assign under_hit = valid & active & (measure < lower);

endmodule : sal_limit_cmp

`default_nettype wire

//--- sal_regs_top.sv
// Alarm limits, alarm masks and lane polarity registers behind an Avalon-MM slave.
// Assumes measurement codes and link events arrive on sys_clk; LP lane pins are asynchronous.
//
// Notes on behaviour
// RQ1: GPIO0 above upper limit raises over flag
// RQ2: GPIO0 below lower limit raises under flag
// RQ3: GPIO1 above upper limit raises over flag
// RQ4: GPIO1 below lower limit raises under flag
// RQ5: Temperature above upper limit raises over flag
// RQ6: Temperature below lower limit raises under flag
// RQ7: Six receive error enables, reset all enabled
// RQ8: Six sensor alarm enables, reset all disabled
// RQ9: Two back-channel enables, reset off, rest reserved
// RQ10: Per-lane HS P/N swap, clock lane bit4
// RQ11: Per-lane LP polarity inversion, clock bit4
// RQ12: Select field picks which GPIOs are measured
// RQ13: Monitor enable field gates all comparisons
// RQ14: Disabled sources never reach combined alarm
`timescale 1ns/1ps
`default_nettype none
`include "sal_map.svh"

module sal_regs_top (
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire logic [7:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic [2:0]         gpio0_meas,
    input  wire logic [2:0]         gpio1_meas,
    input  wire logic [2:0]         temp_meas,
    input  wire logic               meas_valid,
    input  wire logic [5:0]         csi_err_evt,
    input  wire logic [1:0]         bc_evt,
    input  wire sal_pkg::sal_lane_t hs_lane_p_in,
    input  wire sal_pkg::sal_lane_t hs_lane_n_in,
    output sal_pkg::sal_lane_t      hs_lane_p_out,
    output sal_pkg::sal_lane_t      hs_lane_n_out,
    input  wire sal_pkg::sal_lane_t lp_lane_p_pin,
    input  wire sal_pkg::sal_lane_t lp_lane_n_pin,
    output sal_pkg::sal_lane_t      lp_lane_p_out,
    output sal_pkg::sal_lane_t      lp_lane_n_out,
    output logic [1:0]              gpio_vsense_sel,
    output logic [1:0]              monitor_enable,
    output sal_pkg::sal_sense_t     sense_status,
    output logic                    alarm_out
);

    // Bus handshake state
    logic                  wait_ff;       // Waitrequest, high when idle
    logic [31:0]           rdata_ff;      // Captured read word
    logic [5:0]            idx;           // Register index
    logic                  wr_en;         // Write takes effect now
    logic [7:0]            wdat;          // Low write byte
    logic [7:0]            rd_byte;       // Read mux result

    // Configuration registers
    logic [1:0]            mon_en_ff;     // Monitor on/off field
    logic [1:0]            vsel_ff;       // GPIO sensing select
    sal_pkg::sal_limits_t  v0_lim_ff;     // GPIO0 limits
    sal_pkg::sal_limits_t  v1_lim_ff;     // GPIO1 limits
    sal_pkg::sal_limits_t  t_lim_ff;      // Temperature limits
    logic [5:0]            csi_mask_ff;   // Receive error enables
    sal_pkg::sal_sense_t   sns_mask_ff;   // Sensor alarm enables
    logic [1:0]            bc_mask_ff;    // Back-channel enables
    sal_pkg::sal_lane_t    hs_swap_ff;    // HS P/N swap per lane
    sal_pkg::sal_lane_t    lp_inv_ff;     // LP inversion per lane

    // Status and alarm
    sal_pkg::sal_sense_t   sense_ff;      // Sticky sensor flags
    sal_pkg::sal_events_t  evt_ff;        // Sticky link event flags
    sal_pkg::sal_sense_t   nxt_sense;
    sal_pkg::sal_events_t  nxt_evt;
    sal_pkg::sal_sense_t   sns_set;       // Comparator hits this cycle
    logic [5:0]            sns_clr;       // Write-one-to-clear mask
    logic [7:0]            evt_clr;
    logic                  alarm_ff;      // Combined enabled alarm

    // Comparator controls and hits
    logic                  mon_on;
    logic                  v0_act;
    logic                  v1_act;
    logic                  v0_oh, v0_uh, v1_oh, v1_uh, t_oh, t_uh;

    // Lane paths
    sal_pkg::sal_lane_t    hs_p_ff, hs_n_ff;
    sal_pkg::sal_lane_t    lp_p_s1_ff, lp_n_s1_ff;   // First sync stage
    sal_pkg::sal_lane_t    lp_p_s2_ff, lp_n_s2_ff;   // Second sync stage
    sal_pkg::sal_lane_t    lp_p_ff, lp_n_ff;

    // Outputs straight from flops
    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign hs_lane_p_out   = hs_p_ff;
    assign hs_lane_n_out   = hs_n_ff;
    assign lp_lane_p_out   = lp_p_ff;
    assign lp_lane_n_out   = lp_n_ff;
    assign gpio_vsense_sel = vsel_ff;
    assign monitor_enable  = mon_en_ff;
    assign sense_status    = sense_ff;
    assign alarm_out       = alarm_ff;

    // Decode: word aligned, only lane 0 carries data
    assign idx   = avs_address[7:2];
    assign wdat  = avs_writedata[7:0];
    assign wr_en = avs_write & ~wait_ff & avs_byteenable[0];

    // Handshake: one wait cycle, then accept; back to back costs two cycles each
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            if ((avs_read || avs_write) && wait_ff) begin
                wait_ff <= 1'b0;
            end else begin
                wait_ff <= 1'b1;
            end
            // Read word is frozen one cycle before the accepting edge
            if (avs_read && wait_ff) begin
                rdata_ff <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Read mux; reserved and unmapped slots read zero
    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            `SAL_IDX_MON:   rd_byte = {4'h0, mon_en_ff, vsel_ff};
            `SAL_IDX_V0:    rd_byte = {1'b0, v0_lim_ff.upper, 1'b0, v0_lim_ff.lower};
            `SAL_IDX_V1:    rd_byte = {1'b0, v1_lim_ff.upper, 1'b0, v1_lim_ff.lower};
            `SAL_IDX_T:     rd_byte = {1'b0, t_lim_ff.upper, 1'b0, t_lim_ff.lower};
            `SAL_IDX_CSI:   rd_byte = {2'h0, csi_mask_ff};
            `SAL_IDX_SNS:   rd_byte = {2'h0, sns_mask_ff};
            `SAL_IDX_BC:    rd_byte = {6'h00, bc_mask_ff}; // RQ9
            `SAL_IDX_HS:    rd_byte = {3'h0, hs_swap_ff};
            `SAL_IDX_LP:    rd_byte = {3'h0, lp_inv_ff};
            `SAL_IDX_SSTAT: rd_byte = {2'h0, sense_ff};
            `SAL_IDX_ESTAT: rd_byte = evt_ff;
            default:        rd_byte = 8'h00;
        endcase
    end

    // Monitor control and limit registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mon_en_ff <= `SAL_RST_EN;
            vsel_ff   <= `SAL_RST_VSEL;
            v0_lim_ff <= {`SAL_RST_HI, `SAL_RST_LO};
            v1_lim_ff <= {`SAL_RST_HI, `SAL_RST_LO};
            t_lim_ff  <= {`SAL_RST_HI, `SAL_RST_LO};
        end else if (wr_en) begin
            case (idx)
                `SAL_IDX_MON: begin
                    mon_en_ff <= wdat[`SAL_EN_MSB:`SAL_EN_LSB]; // RQ13
                    vsel_ff   <= wdat[`SAL_VSEL_MSB:`SAL_VSEL_LSB]; // RQ12
                end
                `SAL_IDX_V0: v0_lim_ff <= {wdat[`SAL_HI_MSB:`SAL_HI_LSB], wdat[`SAL_LO_MSB:`SAL_LO_LSB]};
                `SAL_IDX_V1: v1_lim_ff <= {wdat[`SAL_HI_MSB:`SAL_HI_LSB], wdat[`SAL_LO_MSB:`SAL_LO_LSB]};
                `SAL_IDX_T:  t_lim_ff  <= {wdat[`SAL_HI_MSB:`SAL_HI_LSB], wdat[`SAL_LO_MSB:`SAL_LO_LSB]};
                default: ;
            endcase
        end
    end

    // Alarm enable and polarity registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            csi_mask_ff <= `SAL_RST_CSI; // RQ7
            sns_mask_ff <= `SAL_RST_SNS; // RQ8
            bc_mask_ff  <= `SAL_RST_BC; // RQ9
            hs_swap_ff  <= `SAL_RST_LANE;
            lp_inv_ff   <= `SAL_RST_LANE;
        end else if (wr_en) begin
            case (idx)
                `SAL_IDX_CSI: csi_mask_ff <= wdat[5:0];
                `SAL_IDX_SNS: sns_mask_ff <= wdat[5:0];
                `SAL_IDX_BC:  bc_mask_ff  <= wdat[1:0];
                `SAL_IDX_HS:  hs_swap_ff  <= wdat[4:0];
                `SAL_IDX_LP:  lp_inv_ff   <= wdat[4:0];
                default: ;
            endcase
        end
    end

    // Comparisons only run while monitors are on; the GPIO ones also need their GPIO selected
    assign mon_on = (mon_en_ff == `SAL_MON_ON); // RQ13
    assign v0_act = mon_on & vsel_ff[`SAL_VSEL_G0]; // RQ12
    assign v1_act = mon_on & vsel_ff[`SAL_VSEL_G1]; // RQ12

    sal_limit_cmp #(.W(3)) u_cmp_v0 ( // RQ1 RQ2
        .measure   (gpio0_meas),
        .valid     (meas_valid),
        .active    (v0_act),
        .upper     (v0_lim_ff.upper),
        .lower     (v0_lim_ff.lower),
        .over_hit  (v0_oh),
        .under_hit (v0_uh)
    );

    sal_limit_cmp #(.W(3)) u_cmp_v1 ( // RQ3 RQ4
        .measure   (gpio1_meas),
        .valid     (meas_valid),
        .active    (v1_act),
        .upper     (v1_lim_ff.upper),
        .lower     (v1_lim_ff.lower),
        .over_hit  (v1_oh),
        .under_hit (v1_uh)
    );

    sal_limit_cmp #(.W(3)) u_cmp_t ( // RQ5 RQ6
        .measure   (temp_meas),
        .valid     (meas_valid),
        .active    (mon_on),
        .upper     (t_lim_ff.upper),
        .lower     (t_lim_ff.lower),
        .over_hit  (t_oh),
        .under_hit (t_uh)
    );

    // Sticky flags: a hit in the clearing cycle survives the clear
    assign sns_set   = {t_oh, t_uh, v1_oh, v1_uh, v0_oh, v0_uh};
    assign sns_clr   = (wr_en && idx == `SAL_IDX_SSTAT) ? wdat[5:0] : 6'h00;
    assign evt_clr   = (wr_en && idx == `SAL_IDX_ESTAT) ? wdat : 8'h00;
    assign nxt_sense = (sense_ff & ~sns_clr) | sns_set; // RQ1
    assign nxt_evt   = (evt_ff & ~evt_clr) | {bc_evt, csi_err_evt};

    // Raw status is kept whatever the enables say
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sense_ff <= 6'h00;
            evt_ff   <= 8'h00;
        end else begin
            sense_ff <= nxt_sense; // RQ2
            evt_ff   <= nxt_evt;
        end
    end

    // Combined alarm: only enabled sources count; one cycle behind the flags
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_ff <= 1'b0;
        end else begin
            alarm_ff <= (|(sense_ff & sns_mask_ff)) | (|(evt_ff.csi & csi_mask_ff))
                      | (|(evt_ff.bc & bc_mask_ff)); // RQ14
        end
    end

    // HS lanes: swap P and N per lane; source is same-clock receiver logic
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hs_p_ff <= 5'h00;
            hs_n_ff <= 5'h00;
        end else begin
            hs_p_ff <= (hs_lane_p_in & ~hs_swap_ff) | (hs_lane_n_in & hs_swap_ff); // RQ10
            hs_n_ff <= (hs_lane_n_in & ~hs_swap_ff) | (hs_lane_p_in & hs_swap_ff); // RQ10
        end
    end

    // LP pins are asynchronous: two flops before any use
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lp_p_s1_ff <= 5'h00;
            lp_n_s1_ff <= 5'h00;
            lp_p_s2_ff <= 5'h00;
            lp_n_s2_ff <= 5'h00;
        end else begin
            lp_p_s1_ff <= lp_lane_p_pin;
            lp_n_s1_ff <= lp_lane_n_pin;
            lp_p_s2_ff <= lp_p_s1_ff;
            lp_n_s2_ff <= lp_n_s1_ff;
        end
    end

    // LP inversion swaps the pair; adds three cycles of latency in total
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lp_p_ff <= 5'h00;
            lp_n_ff <= 5'h00;
        end else begin
            lp_p_ff <= (lp_p_s2_ff & ~lp_inv_ff) | (lp_n_s2_ff & lp_inv_ff); // RQ11
            lp_n_ff <= (lp_n_s2_ff & ~lp_inv_ff) | (lp_p_s2_ff & lp_inv_ff); // RQ11
        end
    end

    // Checks on the flag, mask and lane behaviour
    property p_gpio0_high_alarm_on;
        @(posedge sys_clk) disable iff (!reset_n)
        meas_valid && v0_act && (gpio0_meas > v0_lim_ff.upper) |=> sense_ff.gpio0_high_alarm_on;
    endproperty
    a_gpio0_high_alarm_on: assert property (p_gpio0_high_alarm_on) else $error("gpio0 over flag missing"); // RQ1

    property p_gpio0_low_alarm_on;
        @(posedge sys_clk) disable iff (!reset_n)
        meas_valid && v0_act && (gpio0_meas < v0_lim_ff.lower) |=> sense_ff.gpio0_low_alarm_on;
    endproperty
    a_gpio0_low_alarm_on: assert property (p_gpio0_low_alarm_on) else $error("gpio0 under flag missing"); // RQ2

    property p_gpio1_high_alarm_on;
        @(posedge sys_clk) disable iff (!reset_n)
        meas_valid && v1_act && (gpio1_meas > v1_lim_ff.upper) |-> ##1 sense_ff.gpio1_high_alarm_on;
    endproperty
    a_gpio1_high_alarm_on: assert property (p_gpio1_high_alarm_on) else $error("gpio1 over flag missing"); // RQ3

    property p_gpio1_low_alarm_on;
        @(posedge sys_clk) disable iff (!reset_n)
        !sense_ff.gpio1_low_alarm_on ##1 $rose(sense_ff.gpio1_low_alarm_on) |-> ($past(gpio1_meas) < $past(v1_lim_ff.lower));
    endproperty
    a_gpio1_low_alarm_on: assert property (p_gpio1_low_alarm_on) else $error("gpio1 under flag without cause"); // RQ4

    property p_t_over;
        @(posedge sys_clk) disable iff (!reset_n)
        meas_valid && mon_on && (temp_meas > t_lim_ff.upper) && sns_mask_ff.t_over |-> ##2 alarm_ff;
    endproperty
    a_t_over: assert property (p_t_over) else $error("over-temperature alarm missing"); // RQ5

    property p_t_under;
        @(posedge sys_clk) disable iff (!reset_n)
        meas_valid && mon_on && (temp_meas < t_lim_ff.lower) |=> sense_ff.t_under;
    endproperty
    a_t_under: assert property (p_t_under) else $error("under-temperature flag missing"); // RQ6

    property p_csi_rst;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(reset_n) |-> (csi_mask_ff == 6'h3f);
    endproperty
    a_csi_rst: assert property (p_csi_rst) else $error("receive error enables not all set"); // RQ7

    property p_sns_rst;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(reset_n) |-> (sns_mask_ff == 6'h00) && (v0_lim_ff == 6'h32) && (t_lim_ff == 6'h32);
    endproperty
    a_sns_rst: assert property (p_sns_rst) else $error("sensor enables or limits wrong at reset"); // RQ8

    property p_bc_rsvd;
        @(posedge sys_clk) disable iff (!reset_n)
        avs_read && wait_ff && (idx == `SAL_IDX_BC) |=> (rdata_ff[31:2] == 30'h0) && !wait_ff;
    endproperty
    a_bc_rsvd: assert property (p_bc_rsvd) else $error("back-channel reserved bits not zero"); // RQ9

    property p_hs_swap;
        @(posedge sys_clk) disable iff (!reset_n)
        $past(hs_swap_ff) == 5'h1f |-> (hs_p_ff == $past(hs_lane_n_in)) && (hs_n_ff == $past(hs_lane_p_in));
    endproperty
    a_hs_swap: assert property (p_hs_swap) else $error("hs lanes not swapped"); // RQ10

    property p_lp_inv;
        @(posedge sys_clk) disable iff (!reset_n)
        lp_inv_ff.clk ##1 lp_inv_ff.clk |-> lp_p_ff.clk == $past(lp_lane_n_pin.clk, 3);
    endproperty
    a_lp_inv: assert property (p_lp_inv) else $error("lp clock lane not inverted"); // RQ11

    property p_v0_gated;
        @(posedge sys_clk) disable iff (!reset_n)
        !vsel_ff[`SAL_VSEL_G0] && !sense_ff.gpio0_high_alarm_on && !sense_ff.gpio0_low_alarm_on |=> !sense_ff.gpio0_high_alarm_on && !sense_ff.gpio0_low_alarm_on;
    endproperty
    a_v0_gated: assert property (p_v0_gated) else $error("unselected gpio0 raised a flag"); // RQ12

    property p_mon_off;
        @(posedge sys_clk) disable iff (!reset_n)
        !mon_on && (sense_ff == 6'h00) |=> (sense_ff == 6'h00);
    endproperty
    a_mon_off: assert property (p_mon_off) else $error("flag raised with monitors off"); // RQ13

    property p_masked;
        @(posedge sys_clk) disable iff (!reset_n)
        (sns_mask_ff == 6'h00 && csi_mask_ff == 6'h00 && bc_mask_ff == 2'h0) [*2] |-> !alarm_ff;
    endproperty
    a_masked: assert property (p_masked) else $error("alarm with every source disabled"); // RQ14

endmodule : sal_regs_top

`default_nettype wire

//--- sal_sensor_model.sv
// Image sensor side of the lanes: drives high-speed and low-power lane pairs.
// Assumes the bench steps the lane pattern by non-blocking assignment after a clock edge.
`timescale 1ns/1ps
`default_nettype none

module sal_sensor_model (
    input  wire logic [4:0]         pattern,
    output sal_pkg::sal_lane_t      hs_p,
    output sal_pkg::sal_lane_t      hs_n,
    output sal_pkg::sal_lane_t      lp_p,
    output sal_pkg::sal_lane_t      lp_n
);
    // A real sensor drives each pair differentially, so N is always the complement of P
    assign hs_p = pattern;
    assign hs_n = ~pattern;
    // LP lines are single ended but toggle as a pair here; the swap shows either way
    assign lp_p = pattern;
    assign lp_n = ~pattern;
endmodule : sal_sensor_model

`default_nettype wire

//--- sal_regs_top_bench.sv
// Self-checking bench for the alarm limit, mask and lane polarity register bank.
// Assumes the Avalon slave answers after one wait cycle, but waits for it without counting on that.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin bad_count++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end

module sal_regs_top_bench;
    typedef struct { logic [5:0] idx; logic wr; logic [7:0] wd; logic [7:0] ex; } sal_row_t;
    logic               sys_clk, reset_n;          // Clock and active-low reset
    logic [7:0]         avs_address;               // Byte address
    logic               avs_read, avs_write;       // Requests
    logic [31:0]        avs_writedata, avs_readdata;
    logic               avs_waitrequest;
    logic [2:0]         meas;                      // One code for all three monitors
    logic               meas_valid;
    logic [5:0]         csi_err_evt;
    logic [1:0]         bc_evt;
    logic [4:0]         pattern;                   // Lane pattern driven into the sensor model
    sal_pkg::sal_lane_t hs_p, hs_n, lp_p, lp_n, hs_po, hs_no, lp_po, lp_no;
    logic [1:0]         gpio_vsense_sel, monitor_enable;
    sal_pkg::sal_sense_t sense_status;
    logic               alarm_out;
    int                 bad_count = 0;
    int                 tests_run = 0;
    logic [7:0]         rd;
    sal_row_t rows[19] = '{
        '{6'h17,0,0,8'h0c}, '{6'h19,0,0,8'h62}, '{6'h1a,0,0,8'h62}, '{6'h1b,0,0,8'h62}, '{6'h1c,0,0,8'h3f},
        '{6'h1d,0,0,8'h00}, '{6'h1e,0,0,8'h00}, '{6'h20,0,0,8'h00}, '{6'h21,0,0,8'h00},
        '{6'h19,1,8'hff,8'h77}, '{6'h1a,1,8'h5a,8'h52}, '{6'h1b,1,8'h37,8'h37}, '{6'h1c,1,8'hff,8'h3f},
        '{6'h1d,1,8'hff,8'h3f}, '{6'h1e,1,8'hff,8'h03}, '{6'h1f,1,8'hff,8'h00}, '{6'h20,1,8'hff,8'h1f},
        '{6'h21,1,8'hff,8'h1f}, '{6'h05,1,8'hff,8'h00}};

    sal_sensor_model sal_sensor_model_i (.pattern(pattern), .hs_p(hs_p), .hs_n(hs_n), .lp_p(lp_p), .lp_n(lp_n));
    sal_regs_top sal_regs_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gpio0_meas(meas), .gpio1_meas(meas),
        .temp_meas(meas), .meas_valid(meas_valid), .csi_err_evt(csi_err_evt), .bc_evt(bc_evt),
        .hs_lane_p_in(hs_p), .hs_lane_n_in(hs_n), .hs_lane_p_out(hs_po), .hs_lane_n_out(hs_no),
        .lp_lane_p_pin(lp_p), .lp_lane_n_pin(lp_n), .lp_lane_p_out(lp_po), .lp_lane_n_out(lp_no),
        .gpio_vsense_sel(gpio_vsense_sel), .monitor_enable(monitor_enable), .sense_status(sense_status),
        .alarm_out(alarm_out));

    // 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // One bus cycle; the request is held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [5:0] idx, input logic wr, input logic [7:0] wd, output logic [7:0] q);
        @(posedge sys_clk);
        avs_address   <= {idx, 2'b00};
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= {24'h0, wd};
        // Values read here are those the edge sampled; only the watchdog ends a hung wait
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        // Step off the edge so callers see what the accepting edge launched
        @(negedge sys_clk);
    endtask : bus

    // One-cycle measurement and event pulse, then time for the flag and the alarm to land
    task automatic pulse(input logic [2:0] g, input logic [5:0] ce, input logic [1:0] be);
        @(posedge sys_clk);
        meas        <= g;
        meas_valid  <= 1'b1;
        csi_err_evt <= ce;
        bc_evt      <= be;
        @(posedge sys_clk);
        meas_valid  <= 1'b0;
        csi_err_evt <= 6'h00;
        bc_evt      <= 2'h0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : pulse

    // Closing task shared by the main sequence and the watchdog
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    // Watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        reset_n = 1'b0; avs_address = 8'h00; avs_read = 1'b0; avs_write = 1'b0; avs_writedata = 32'h0;
        meas = 3'h0; meas_valid = 1'b0; csi_err_evt = 6'h00; bc_evt = 2'h0; pattern = 5'h00;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(negedge sys_clk);
        `CHK("monitor_enable", 2'h3, monitor_enable)
        `CHK("gpio_vsense_sel", 2'h0, gpio_vsense_sel)
        $display("Test reset outputs done");
        // Reset values, write masks, reserved and unmapped places
        foreach (rows[i]) begin
            if (rows[i].wr) bus(rows[i].idx, 1'b1, rows[i].wd, rd);
            bus(rows[i].idx, 1'b0, 8'h00, rd);
            `CHK("register", rows[i].ex, rd)
        end
        $display("Test register table done");
        // Limits back to 6 and 2, all sensor alarms on, GPIO0 only
        foreach (rows[i]) if (i >= 1 && i <= 3) bus(rows[i].idx, 1'b1, 8'h62, rd);
        bus(6'h1d, 1'b1, 8'h3f, rd);
        bus(6'h17, 1'b1, 8'h0d, rd);
        `CHK("select", 2'h1, gpio_vsense_sel)
        // Every code against the strict window, GPIO1 left unselected
        for (int g = 0; g < 8; g++) begin
            bus(6'h38, 1'b1, 8'h3f, rd);
            pulse(g[2:0], 6'h00, 2'h0);
            `CHK("sense", {g > 6, g < 2, 2'b00, g > 6, g < 2}, sense_status)
            `CHK("alarm", (g > 6) || (g < 2), alarm_out)
        end
        // GPIO1 only, low code
        bus(6'h17, 1'b1, 8'h0e, rd);
        bus(6'h38, 1'b1, 8'h3f, rd);
        pulse(3'h0, 6'h00, 2'h0);
        `CHK("sense v1", 6'h14, sense_status)
        // Masks cleared: raw flags still recorded, no combined alarm
        bus(6'h1d, 1'b1, 8'h00, rd);
        bus(6'h1c, 1'b1, 8'h00, rd);
        bus(6'h1e, 1'b1, 8'h00, rd);
        bus(6'h38, 1'b1, 8'h3f, rd);
        pulse(3'h7, 6'h00, 2'h0);
        `CHK("sense masked", 6'h28, sense_status)
        `CHK("alarm masked", 1'b0, alarm_out)
        // Monitors off: no comparison at all
        bus(6'h17, 1'b1, 8'h03, rd);
        bus(6'h38, 1'b1, 8'h3f, rd);
        pulse(3'h7, 6'h00, 2'h0);
        `CHK("sense off", 6'h00, sense_status)
        $display("Test limits done");
        // Back-channel event with its enable off, then a length error with only its enable on
        bus(6'h1c, 1'b1, 8'h01, rd);
        bus(6'h39, 1'b1, 8'hff, rd);
        pulse(3'h3, 6'h00, 2'h2);
        `CHK("alarm bc off", 1'b0, alarm_out)
        bus(6'h39, 1'b0, 8'h00, rd);
        `CHK("event status", 8'h80, rd)
        pulse(3'h3, 6'h20, 2'h0);
        `CHK("alarm csi masked", 1'b0, alarm_out)
        pulse(3'h3, 6'h01, 2'h0);
        `CHK("alarm csi", 1'b1, alarm_out)
        $display("Test alarm masks done");
        // Lane swaps on a mixed pattern of bits
        bus(6'h20, 1'b1, 8'h15, rd);
        bus(6'h21, 1'b1, 8'h0a, rd);
        @(posedge sys_clk);
        pattern <= 5'h0b;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK("hs p", 5'h1e, hs_po)
        `CHK("hs n", 5'h01, hs_no)
        `CHK("lp p", 5'h01, lp_po)
        `CHK("lp n", 5'h1e, lp_no)
        $display("Test lanes done");
        print_verdict();
    end
endmodule : sal_regs_top_bench

`default_nettype wire
